// ### rtl/wdg_watchdog.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module wdg_watchdog
   import wdg_pkg::*;
#(
   parameter int BASE_CYCLES = BASE_OSC_CYCLES,
   parameter int CNT_W       = 20
) (
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       osc_clk_in,
   input  wire logic       restart_req,
   input  wire logic       vector_ack,
   input  wire logic       global_irq_enable,
   input  wire logic       always_on_fuse,
   input  wire logic       brownout_event,
   input  wire logic       pin_reset_event,
   output logic            timeout_irq,
   output logic            dog_reset_pulse
);

   if (BASE_CYCLES < 1 || CNT_W > 30 ||
       (longint'(BASE_CYCLES) << 9) > (longint'(1) << CNT_W)) begin : g_chk
      $error("wdg_watchdog: counter too narrow for the longest period");
   end

   typedef struct packed {
      logic             osc_meta;
      logic             osc_sync;
      logic             osc_prev;
      logic [CNT_W-1:0] count;
      logic [3:0]       cause;
      logic             irq_flag;
      logic             irq_en;
      logic             rst_en;
      logic [3:0]       period;
      logic [2:0]       unlock_cnt;
      logic [7:0]       rdata;
      logic             irq_req;
      logic             dog_rst;
   } wdg_state_t;

   localparam wdg_state_t STATE_RESET = '{
      osc_meta:   1'h0,
      osc_sync:   1'h0,
      osc_prev:   1'h0,
      count:      '0,
      cause:      CAUSE_RESET,
      irq_flag:   1'h0,
      irq_en:     1'h0,
      rst_en:     1'h0,
      period:     PERIOD_RESET,
      unlock_cnt: 3'h0,
      rdata:      8'h00,
      irq_req:    1'h0,
      dog_rst:    1'h0
   };

   wdg_state_t s;
   wdg_state_t next_s;

   logic       fuse_prog;
   logic       tick;
   logic       unlocked;
   logic       rst_en_rd;
   logic       irq_en_rd;
   logic       timeout;
   logic       sys_rst;
   logic       cause_wr;
   logic       ctrl_wr;
   wdg_mode_t  mode;

   // Action on time-out from fuse and enables
   function automatic wdg_mode_t eff_mode(input logic fuse,
                                          input logic rst_enable,
                                          input logic irq_enable);
      wdg_mode_t m;
      m = WDG_RESET;
      if (!fuse) begin
         unique case ({rst_enable, irq_enable})
            2'h0: m = WDG_STOPPED;
            2'h1: m = WDG_IRQ;
            2'h2: m = WDG_RESET;
            2'h3: m = WDG_IRQ_RESET;
         endcase
      end
      return m;
   endfunction

   // Last count before time-out; reserved codes act as the longest
   function automatic logic [CNT_W-1:0] period_last(input logic [3:0] code);
      logic [3:0]     eff;
      logic [CNT_W:0] lim;
      eff = (code > PERIOD_MAX_CODE) ? PERIOD_MAX_CODE : code;
      lim = (CNT_W+1)'(BASE_CYCLES) << eff;
      return CNT_W'(lim - 1'h1);
   endfunction

   assign fuse_prog = (always_on_fuse == FUSE_PROGRAMMED);
   assign tick      = s.osc_sync & ~s.osc_prev;
   assign unlocked  = (s.unlock_cnt != 3'h0);
   assign rst_en_rd = s.rst_en | s.cause[CAUSE_DOG] | fuse_prog;
   assign irq_en_rd = s.irq_en & ~fuse_prog;
   assign mode      = eff_mode(fuse_prog, rst_en_rd, irq_en_rd);
   assign timeout   = tick & ~restart_req &
                      (s.count == period_last(s.period));
   assign cause_wr  = reg_wr & (reg_addr == ADDR_CAUSE);
   assign ctrl_wr   = reg_wr & (reg_addr == ADDR_CTRL);

   always_comb begin
      logic dog;
      dog    = 1'h0;
      next_s = s;

      // Oscillator edge crossing
      next_s.osc_meta = osc_clk_in;
      next_s.osc_sync = s.osc_meta;
      next_s.osc_prev = s.osc_sync;

      if (unlocked) begin
         next_s.unlock_cnt = s.unlock_cnt - 3'h1;
      end

      // Counter
      if (restart_req) begin
         next_s.count = '0;
      end else if (tick) begin
         if (timeout) begin
            next_s.count = '0;
         end else begin
            next_s.count = s.count + 1'h1;
         end
      end

      // Status register writes: zero clears
      if (cause_wr) begin
         for (int i = 0; i < 4; i++) begin
            if (!reg_wdata[i]) begin
               next_s.cause[i] = 1'h0;
            end
         end
      end

      // Control register writes
      if (ctrl_wr) begin
         if (reg_wdata[CTRL_IRQ_FLAG]) begin
            next_s.irq_flag = 1'h0;
         end
         if (!fuse_prog) begin
            next_s.irq_en = reg_wdata[CTRL_IRQ_EN];
         end
         if (reg_wdata[CTRL_UNLOCK]) begin
            next_s.unlock_cnt = UNLOCK_CYCLES;
         end
         if (reg_wdata[CTRL_RST_EN]) begin
            next_s.rst_en = 1'h1;
         end else if (unlocked) begin
            next_s.rst_en = 1'h0;
         end
         if (unlocked) begin
            next_s.period = {reg_wdata[CTRL_PER_HI], reg_wdata[2:0]};
         end
      end

      // Vector executed by the core
      if (vector_ack) begin
         next_s.irq_flag = 1'h0;
         if (mode == WDG_IRQ_RESET) begin
            next_s.irq_en = 1'h0;
         end
      end

      // Time-out action; set wins over write and vector clears, not over a system reset
      if (timeout) begin
         unique case (mode)
            WDG_STOPPED: ;
            WDG_IRQ: next_s.irq_flag = 1'h1;
            WDG_RESET: dog = 1'h1;
            WDG_IRQ_RESET: begin
               if (s.irq_flag) begin
                  dog = 1'h1;
               end else begin
                  next_s.irq_flag = 1'h1;
               end
            end
         endcase
      end

      // System reset returns the control register to defaults
      if (dog | brownout_event | pin_reset_event) begin
         next_s.count      = '0;
         next_s.irq_flag   = 1'h0;
         next_s.irq_en     = 1'h0;
         next_s.rst_en     = 1'h0;
         next_s.period     = PERIOD_RESET;
         next_s.unlock_cnt = 3'h0;
      end
      if (dog) begin
         next_s.cause[CAUSE_DOG] = 1'h1;
      end
      if (brownout_event) begin
         next_s.cause[CAUSE_BROWN] = 1'h1;
      end
      if (pin_reset_event) begin
         next_s.cause[CAUSE_PIN] = 1'h1;
      end
      if (next_s.cause[CAUSE_DOG]) begin
         next_s.rst_en = 1'h1;
      end
      next_s.dog_rst = dog;

      next_s.irq_req = next_s.irq_flag & next_s.irq_en & ~fuse_prog &
                       global_irq_enable;

      // Read data, one cycle after the strobe
      next_s.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == ADDR_CAUSE) begin
            next_s.rdata = {4'h0, s.cause};
         end else if (reg_addr == ADDR_CTRL) begin
            next_s.rdata = {s.irq_flag, irq_en_rd, s.period[3], unlocked,
                            rst_en_rd, s.period[2:0]};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign sys_rst         = next_s.dog_rst | brownout_event | pin_reset_event;
   assign reg_rdata       = s.rdata;
   assign timeout_irq     = s.irq_req;
   assign dog_reset_pulse = s.dog_rst;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   a_cause_upper_zero: assert property (
      reg_rd && reg_addr == ADDR_CAUSE |=> reg_rdata[7:4] == 4'h0)
      else $error("status upper bits not zero");

   a_dog_flag_set: assert property (
      dog_reset_pulse |-> s.cause[CAUSE_DOG])
      else $error("watchdog reset without flag");

   a_brown_flag_set: assert property (
      brownout_event |=> s.cause[CAUSE_BROWN])
      else $error("brown-out flag not set");

   a_pin_flag_set: assert property (
      pin_reset_event |=> s.cause[CAUSE_PIN])
      else $error("pin reset flag not set");

   a_pon_flag_kept: assert property (
      s.cause[CAUSE_PON] && !(cause_wr && !reg_wdata[CAUSE_PON])
      |=> s.cause[CAUSE_PON])
      else $error("power-on flag lost without a write");

   a_irq_flag_set: assert property (
      timeout && mode == WDG_IRQ && !brownout_event && !pin_reset_event
      |=> s.irq_flag)
      else $error("time-out did not set interrupt flag");

   a_vector_clears: assert property (
      vector_ack && !timeout |=> !s.irq_flag)
      else $error("vector did not clear flag");

   a_irq_gated: assert property (
      timeout_irq |-> s.irq_flag && s.irq_en && $past(global_irq_enable))
      else $error("interrupt request without enables");

   a_combined_fallback: assert property (
      vector_ack && mode == WDG_IRQ_RESET |=> !s.irq_en && !s.irq_flag)
      else $error("combined mode did not fall back");

   a_combined_reset: assert property (
      timeout && mode == WDG_IRQ_RESET && s.irq_flag |=> dog_reset_pulse)
      else $error("second time-out gave no reset");

   a_fuse_forces: assert property (
      timeout && fuse_prog |=> dog_reset_pulse)
      else $error("fuse did not force reset");

   a_period_locked: assert property (
      ctrl_wr && !unlocked && !sys_rst |=> $stable(s.period))
      else $error("period changed while locked");

   a_unlock_expiry: assert property (
      (ctrl_wr && reg_wdata[CTRL_UNLOCK])
      ##1 !(ctrl_wr && reg_wdata[CTRL_UNLOCK]) [*4]
      |=> s.unlock_cnt == 3'h0)
      else $error("change unlock not cleared after four cycles");

   a_rst_en_override: assert property (
      s.cause[CAUSE_DOG] && reg_rd && reg_addr == ADDR_CTRL
      |=> reg_rdata[CTRL_RST_EN])
      else $error("reset enable read clear while flag set");

   a_restart_zero: assert property (
      restart_req |=> s.count == '0)
      else $error("restart did not zero counter");

   a_reset_one_cycle: assert property (
      dog_reset_pulse |=> !dog_reset_pulse)
      else $error("reset pulse longer than one cycle");

   a_write_one_clears: assert property (
      ctrl_wr && reg_wdata[CTRL_IRQ_FLAG] && !timeout |=> !s.irq_flag)
      else $error("written one did not clear flag");

   a_stopped_quiet: assert property (
      timeout && mode == WDG_STOPPED
      |=> !dog_reset_pulse && !$rose(s.irq_flag))
      else $error("stopped mode acted on time-out");

   a_irq_mode_quiet: assert property (
      timeout && mode == WDG_IRQ |=> !dog_reset_pulse)
      else $error("interrupt mode gave a reset");

   a_rst_en_locked: assert property (
      ctrl_wr && !unlocked && s.rst_en && !sys_rst |=> s.rst_en)
      else $error("reset enable cleared while locked");

   a_unlock_open: assert property (
      ctrl_wr && reg_wdata[CTRL_UNLOCK] && !sys_rst
      |=> s.unlock_cnt == UNLOCK_CYCLES)
      else $error("change unlock window not opened");

   a_rst_en_held: assert property (
      s.cause[CAUSE_DOG] |-> s.rst_en)
      else $error("reset enable not held by flag");

   c_irq_timeout: cover property (timeout && mode == WDG_IRQ);
   c_combined_reset: cover property (
      timeout && mode == WDG_IRQ_RESET && s.irq_flag);
   c_unlock_change: cover property (
      (ctrl_wr && reg_wdata[CTRL_UNLOCK]) ##[1:4] (ctrl_wr && unlocked));
   c_vector_exec: cover property (vector_ack && s.irq_flag);
   c_fuse_reset: cover property (timeout && fuse_prog);

endmodule // wdg_watchdog

// ### rtl/wdg_pkg.sv
// Overview of operation
// - Status register bits 7..4 always read as zero.
// - Bit 3 dog_reset_flag: set on watchdog reset, cleared by power-on or zero write.
// - Bit 2 brownout_reset_flag: set on brown-out, cleared by power-on or zero write.
// - Bit 1 pin_reset_flag: set on pin reset, cleared by power-on or zero write.
// - Bit 0 poweron_reset_flag: set on power-on, cleared only by zero write.
// - Control bit 7 timeout_irq_flag sets on time-out in interrupt operation.
// - Interrupt flag clears on vector execution or on a written one.
// - Interrupt requested only while global enable and timeout_irq_enable are set.
// - Combined mode: vector execution clears enable and flag, leaving reset-only.
// - Combined mode: second time-out without vector execution gives system reset.
// - Unprogrammed fuse: reset and irq enables pick none, irq, reset, irq-then-reset.
// - Programmed always-on fuse forces system reset mode.
// - Clearing reset enable or changing period needs change_unlock set.
// - change_unlock clears itself four system clock cycles after being written.
// - Reset enable reads set while dog_reset_flag is set.
// - Period select sits at control bit 5 (msb) and bits 2..0.
// - Codes 0..9 give 2048 to 1048576 oscillator cycles; 10..15 reserved.
// - The counter counts cycles of the separate low-rate oscillator.
// - A restart request returns the counter to zero.
// - A watchdog system reset is a one-cycle pulse.
package wdg_pkg;
   localparam logic [7:0] ADDR_CAUSE      = 8'h35;
   localparam logic [7:0] ADDR_CTRL       = 8'h60;
   localparam int         CAUSE_DOG       = 3;
   localparam int         CAUSE_BROWN     = 2;
   localparam int         CAUSE_PIN       = 1;
   localparam int         CAUSE_PON       = 0;
   localparam int         CTRL_IRQ_FLAG   = 7;
   localparam int         CTRL_IRQ_EN     = 6;
   localparam int         CTRL_PER_HI     = 5;
   localparam int         CTRL_UNLOCK     = 4;
   localparam int         CTRL_RST_EN     = 3;
   localparam logic [3:0] CAUSE_RESET     = 4'h1;
   localparam logic [3:0] PERIOD_RESET    = 4'h0;
   localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
   localparam logic [2:0] UNLOCK_CYCLES   = 3'h4;
   localparam logic       FUSE_PROGRAMMED = 1'h0;
   localparam int         BASE_OSC_CYCLES = 2048;

   typedef enum logic [1:0] {
      WDG_STOPPED,
      WDG_IRQ,
      WDG_RESET,
      WDG_IRQ_RESET
   } wdg_mode_t;
endpackage

// ### verif/wdg_core_model.sv
`timescale 1ns/1ps
module wdg_core_model (
   input  wire logic clk_sys,
   input  wire logic reset_n,
   input  wire logic timeout_irq,
   input  wire logic ack_en,
   output logic      vector_ack = 1'b0,
   output logic      osc_clk_in = 1'b0
);
   logic [1:0] wait_cnt = 2'h0;

   // Free-running oscillator stand-in, unrelated to clk_sys
   always #85 osc_clk_in = ~osc_clk_in;

   // Vector taken a few cycles after the request; enable not re-set here
   always @(posedge clk_sys) begin
      if (!reset_n || !ack_en || vector_ack || !timeout_irq) begin
         wait_cnt   <= 2'h0;
         vector_ack <= 1'b0;
      end else begin
         wait_cnt   <= wait_cnt + 2'h1;
         vector_ack <= (wait_cnt == 2'h2);
      end
   end
endmodule  // wdg_core_model

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench
   import wdg_pkg::*;
;
   logic        clk_sys, reset_n, reg_wr, reg_rd, restart_req, ack_en;
   logic        global_irq_enable, always_on_fuse, brownout_event;
   logic        pin_reset_event, vector_ack, osc_clk_in, timeout_irq;
   logic        dog_reset_pulse, rd_q;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [7:0]  expq[$];
   logic [15:0] lfsr;
   int          errors, comparisons, pulses, tick_n, n;

   wdg_watchdog #(.BASE_CYCLES(4), .CNT_W(20)) i_wdg_watchdog (
      .clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .osc_clk_in, .restart_req, .vector_ack,
      .global_irq_enable, .always_on_fuse, .brownout_event,
      .pin_reset_event, .timeout_irq, .dog_reset_pulse);

   wdg_core_model i_wdg_core_model (
      .clk_sys, .reset_n, .timeout_irq, .ack_en, .vector_ack, .osc_clk_in);

   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   function automatic logic [7:0] spare(input logic [7:0] a);
      return (a == ADDR_CAUSE || a == ADDR_CTRL) ? 8'h36 : a;
   endfunction

   task automatic check(input string what, input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Every write also restarts the counter
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_sys);
      {reg_addr, reg_wdata, reg_wr, restart_req} <= {a, d, 2'h3};
      @(posedge clk_sys);
      {reg_wr, restart_req} <= 2'h0;
      tick_n = 0;
   endtask

   task automatic rd(input logic [7:0] a, exp);
      @(posedge clk_sys);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      expq.push_back(exp);
   endtask

   task automatic wt(input bit dog);
      int k;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while ((dog ? dog_reset_pulse : timeout_irq) !== 1'b1 && k < 3000);
      check("wait", 8'(k < 3000), 8'h01);
   endtask

   task automatic pulse_ev(input logic brown);
      @(posedge clk_sys);
      {brownout_event, pin_reset_event} <= {brown, !brown};
      @(posedge clk_sys);
      {brownout_event, pin_reset_event} <= 2'h0;
   endtask

   always @(posedge clk_sys) begin
      if (rd_q)
         check("read data", reg_rdata, expq.pop_front());
      rd_q <= reg_rd;
      if (dog_reset_pulse === 1'b1)
         pulses++;
   end

   always @(posedge osc_clk_in) tick_n++;

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      #400000;
      errors++;
      close_out();
   end

   initial begin
      {reg_wr, reg_rd, restart_req, ack_en, global_irq_enable} = 5'h00;
      {brownout_event, pin_reset_event, rd_q, reset_n} = 4'h0;
      always_on_fuse = 1'b1;
      {reg_addr, reg_wdata} = 16'h0000;
      lfsr = 16'h3E9B;
      {errors, comparisons, pulses, tick_n} = '0;
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      // Reset cause flags
      rd(ADDR_CAUSE, 8'h01);
      rd(ADDR_CTRL, 8'h00);
      wr(ADDR_CAUSE, 8'h00);
      rd(ADDR_CAUSE, 8'h00);
      pulse_ev(1'b1);
      rd(ADDR_CAUSE, 8'h04);
      pulse_ev(1'b0);
      rd(ADDR_CAUSE, 8'h06);
      wr(ADDR_CAUSE, 8'hF2);
      rd(ADDR_CAUSE, 8'h02);
      wr(ADDR_CAUSE, 8'h00);
      n = pulses;
      repeat (300) @(posedge clk_sys);
      check("stopped irq", {7'h00, timeout_irq}, 8'h00);
      // Interrupt mode
      wr(ADDR_CTRL, 8'h40);
      global_irq_enable <= 1'b1;
      wt(1'b0);
      rd(ADDR_CTRL, 8'hC0);
      global_irq_enable <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check("masked irq", {7'h00, timeout_irq}, 8'h00);
      wr(ADDR_CTRL, 8'hC0);
      rd(ADDR_CTRL, 8'h40);
      {ack_en, global_irq_enable} <= 2'h3;
      wt(1'b0);
      repeat (6) @(posedge clk_sys);
      rd(ADDR_CTRL, 8'h40);
      check("no reset", 8'(pulses - n), 8'h00);
      // Combined mode, vector taken then reset-only
      wr(ADDR_CTRL, 8'hC8);
      wt(1'b0);
      repeat (6) @(posedge clk_sys);
      rd(ADDR_CTRL, 8'h08);
      wt(1'b1);
      @(posedge clk_sys);
      check("pulse", {7'h00, dog_reset_pulse}, 8'h00);
      rd(ADDR_CAUSE, 8'h08);
      rd(ADDR_CTRL, 8'h08);
      // Combined mode, vector not taken
      ack_en <= 1'b0;
      wr(ADDR_CTRL, 8'h40);
      n = pulses;
      wt(1'b0);
      check("early reset", 8'(pulses - n), 8'h00);
      wt(1'b1);
      wr(ADDR_CAUSE, 8'h00);
      rd(ADDR_CTRL, 8'h08);
      global_irq_enable <= 1'b0;
      // Timed change sequence
      wr(ADDR_CTRL, 8'h08);
      wr(ADDR_CTRL, 8'h01);
      rd(ADDR_CTRL, 8'h08);
      wr(ADDR_CTRL, 8'h18);
      repeat (3) @(posedge clk_sys);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_CTRL, 8'h08);
      wr(ADDR_CTRL, 8'h18);
      repeat (2) @(posedge clk_sys);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_CTRL, 8'h00);
      // Random restarts through unmapped traffic
      wr(ADDR_CTRL, 8'h08);
      n = pulses;
      for (int i = 0; i < 30; i++) begin
         lfsr = lfsr_next(lfsr);
         wr(spare(lfsr[7:0]), lfsr[15:8]);
         rd(spare(lfsr[15:8]), 8'h00);
         repeat (lfsr[2:0]) @(posedge clk_sys);
      end
      check("restart", 8'(pulses - n), 8'h00);
      rd(ADDR_CTRL, 8'h08);
      // Period codes
      for (int c = 0; c < 3; c++) begin
         wr(ADDR_CTRL, 8'h18);
         wr(ADDR_CTRL, 8'h08 | 8'(c));
         rd(ADDR_CTRL, 8'h18 | 8'(c));
         wt(1'b1);
         check("ticks", 8'(tick_n >= (4 << c) - 1
                           && tick_n <= (4 << c) + 1), 8'h01);
         wr(ADDR_CAUSE, 8'h00);
      end
      wr(ADDR_CTRL, 8'h18);
      wr(ADDR_CTRL, 8'h2A);
      rd(ADDR_CTRL, 8'h3A);
      // Always-on fuse programmed
      {reset_n, always_on_fuse} <= 2'h0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      wr(ADDR_CTRL, 8'h40);
      rd(ADDR_CTRL, 8'h08);
      wt(1'b1);
      rd(ADDR_CAUSE, 8'h09);
      repeat (2) @(posedge clk_sys);
      close_out();
   end
endmodule  // testbench
